//--- pkg/cnp_pkg.sv
// Purpose: Shared constants and types of the center network port block
// Assumes: Core clock of 250 MHz
// Notes: Serial bit timing is built from quarter-bit ticks; strobe and pulse lengths count core cycles

package cnp_pkg;

  // --------------------------------------------------------------------
  // Clock and timing
  // --------------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 250;
  // Highest external baud clock, in kHz
  localparam int EXT_CLK_MAX_KHZ = 12500;
  // Quarter ticks per bit; external clock edges per bit
  localparam int QTICKS_PER_BIT = 4;
  // Core cycles per quarter tick for the internal rates
  localparam logic [7:0] QDIV_RATE1 = 8'h19;
  localparam logic [7:0] QDIV_RATE2 = 8'h32;
  localparam logic [7:0] QDIV_RATE3 = 8'h64;
  // Idle toggle half period, in bit periods
  localparam int IDLE_HALF_BITS = 2;
  // Buffer write pulse low time
  localparam int WR_LOW_NS = 20;
  localparam int WR_LOW_CYC = (WR_LOW_NS * CORE_CLK_MHZ + 999) / 1000;
  // Length of scan progress and check pulses
  localparam int PULSE_CYC = 16;

  // --------------------------------------------------------------------
  // Packet layout
  // --------------------------------------------------------------------
  localparam int PKT_BITS = 16;
  localparam int REQ_BIT = 15;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [PKT_BITS-1:0] data;
    logic last;
  } cnp_tx_req_s;

  typedef struct packed {
    logic [PKT_BITS-1:0] data;
    logic from_secondary;
    logic last;
  } cnp_rx_resp_s;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_START = 2'h1,
    TX_DATA = 2'h3
  } cnp_tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_HALF = 2'h1,
    RX_DATA = 2'h3,
    RX_STORE = 2'h2
  } cnp_rx_state_e;

endpackage : cnp_pkg

//--- rtl/cnp_top.sv
// Purpose: Network and status pins of a polling center controller
// Assumes: Static straps; inputs synchronous except serial and baud clock
// Notes: Frame is a low start bit then data LSB first
//
// Functional notes
// R1 - Send each command packet serially on the transmit output.
// R2 - Gate output high whenever the transmit output is enabled.
// R3 - On simultaneous responses take the primary input, ignore secondary.
// R4 - Outside party holds the unused secondary input high.
// R5 - Duplex select high means full duplex, low means half duplex.
// R6 - Host width select low means an 8-bit host bus.
// R7 - External baud clock divided by four gives the bit rate.
// R8 - Raise request output when a response carries the request flag.
// R9 - Pulse after the final satellite's data is loaded into a packet.
// R10 - Pulse after the final satellite's response is written to memory.
// R11 - Each check output goes high for a fixed time per event.
// R12 - Active-low read and write strobes drive the buffer memory.
// R13 - Outside party holds the buffer type select high.
// R14 - Both rate selects low selects the external baud clock.
// R15 - Gate always high in full duplex, only while sending in half.
// R16 - In half duplex ignore receive inputs while the gate is high.
// R17 - Between packets toggle transmit output every two bit periods.
// R18 - Receive inputs and baud clock pass two synchroniser stages.
// R19 - Progress and check pulses last a fixed number of core cycles.

`timescale 1ns/1ps

module cnp_top (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic duplex_select_i,
  input wire logic host_width_select_i,
  input wire logic rate_sel_lo_i,
  input wire logic rate_sel_hi_i,
  input wire logic ext_baud_clock_i,
  input wire logic buffer_type_select_i,
  input wire logic serial_in_primary_i,
  input wire logic serial_in_secondary_i,
  input wire logic tx_valid_i,
  input wire cnp_pkg::cnp_tx_req_s tx_req_i,
  output logic tx_ready_o,
  output logic serial_out_o,
  output logic line_drive_gate_o,
  input wire logic rx_last_i,
  output logic rx_valid_o,
  output cnp_pkg::cnp_rx_resp_s rx_resp_o,
  output logic satellite_request_flag_o,
  input wire logic [1:0] check_evt_i,
  output logic check_out_first_o,
  output logic check_out_second_o,
  output logic last_tx_loaded_pulse_o,
  output logic last_rx_stored_pulse_o,
  output logic buffer_read_strobe_n_o,
  output logic buffer_write_strobe_n_o,
  output logic host_bus_8bit_o,
  output logic buffer_type_ok_o
);

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic ext_prev_q;
  logic [1:0] rx_prev_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      ext_prev_q <= 1'b1;
      rx_prev_q <= 2'h3;
    end else begin
      sync1_q <= {ext_baud_clock_i, serial_in_secondary_i,
                  serial_in_primary_i}; // R18
      sync2_q <= sync1_q; // R18
      ext_prev_q <= sync2_q[2];
      rx_prev_q <= sync2_q[1:0];
    end
  end

  wire rx_pri = sync2_q[0];
  wire rx_sec = sync2_q[1];

  // --------------------------------------------------------------------
  // Quarter-bit tick
  // --------------------------------------------------------------------
  logic [7:0] div_q;
  wire ext_mode = !rate_sel_lo_i && !rate_sel_hi_i; // R14
  wire ext_edge = sync2_q[2] && !ext_prev_q;
  wire [7:0] qdiv_sel = rate_sel_hi_i ?
                        (rate_sel_lo_i ? cnp_pkg::QDIV_RATE3
                                       : cnp_pkg::QDIV_RATE2)
                        : cnp_pkg::QDIV_RATE1;
  wire div_end = (div_q == qdiv_sel - 8'h01);
  // One bit spans four ticks, so four external edges per bit
  wire qtick = ext_mode ? ext_edge : div_end; // R7

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || ext_mode || div_end) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // --------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------
  cnp_pkg::cnp_tx_state_e tx_state_q;
  logic [1:0] tq_cnt_q;
  logic [4:0] tbit_q;
  logic [cnp_pkg::PKT_BITS-1:0] tsh_q;
  logic idle_lvl_q;
  logic [1:0] idle_bits_q;
  logic serial_out_q;
  logic gate_q;
  logic tx_last_evt_q;

  wire tx_take = tx_valid_i && (tx_state_q == cnp_pkg::TX_IDLE);
  wire tx_bit_end = qtick && (tq_cnt_q == 2'(cnp_pkg::QTICKS_PER_BIT - 1));
  wire tx_last_bit = (tbit_q == 5'(cnp_pkg::PKT_BITS - 1));
  wire idle_flip = tx_bit_end &&
                   (idle_bits_q == 2'(cnp_pkg::IDLE_HALF_BITS - 1));
  wire serial_out_d = (tx_state_q == cnp_pkg::TX_IDLE) ? idle_lvl_q :
                      (tx_state_q == cnp_pkg::TX_START) ? 1'b0 :
                      tsh_q[0];
  wire gate_d = duplex_select_i ||
                (tx_state_q != cnp_pkg::TX_IDLE); // R15

  assign tx_ready_o = (tx_state_q == cnp_pkg::TX_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || tx_take) begin
      tq_cnt_q <= 2'h0;
    end else if (qtick) begin
      tq_cnt_q <= tq_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      tx_state_q <= cnp_pkg::TX_IDLE;
      tbit_q <= 5'h00;
      tsh_q <= '0;
      tx_last_evt_q <= 1'b0;
    end else begin
      tx_last_evt_q <= tx_take && tx_req_i.last; // R9
      unique case (tx_state_q)
        cnp_pkg::TX_IDLE: begin
          if (tx_take) begin
            tsh_q <= tx_req_i.data;
            tx_state_q <= cnp_pkg::TX_START;
          end
        end
        cnp_pkg::TX_START: begin
          if (tx_bit_end) begin
            tbit_q <= 5'h00;
            tx_state_q <= cnp_pkg::TX_DATA;
          end
        end
        cnp_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tsh_q <= tsh_q >> 1; // R1
            tbit_q <= tbit_q + 5'h01;
            if (tx_last_bit) begin
              tx_state_q <= cnp_pkg::TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_q <= cnp_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Idle pattern between packets
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || tx_state_q != cnp_pkg::TX_IDLE) begin
      idle_bits_q <= 2'h0;
      idle_lvl_q <= 1'b1;
    end else if (idle_flip) begin
      idle_bits_q <= 2'h0;
      idle_lvl_q <= !idle_lvl_q; // R17
    end else if (tx_bit_end) begin
      idle_bits_q <= idle_bits_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      serial_out_q <= 1'b1;
      gate_q <= 1'b0;
    end else begin
      serial_out_q <= serial_out_d; // R1
      gate_q <= gate_d; // R2 R5
    end
  end

  assign serial_out_o = serial_out_q;
  assign line_drive_gate_o = gate_q;

  // --------------------------------------------------------------------
  // Receiver and buffer write
  // --------------------------------------------------------------------
  cnp_pkg::cnp_rx_state_e rx_state_q;
  logic [1:0] rq_cnt_q;
  logic [4:0] rbit_q;
  logic [2:0] wcnt_q;
  logic rx_sel_q;
  logic [cnp_pkg::PKT_BITS-1:0] rsh_q;
  cnp_pkg::cnp_rx_resp_s rx_resp_q;
  logic rx_valid_q;
  logic req_flag_q;
  logic rx_last_evt_q;
  logic rd_n_q;
  logic wr_n_q;

  // Own echo must not be taken as a response
  wire rx_blocked = !duplex_select_i && gate_q; // R16
  wire rx_bit = rx_sel_q ? rx_sec : rx_pri;
  // Falling edges only, so a low last data bit is no new start
  wire fall_pri = !rx_pri && rx_prev_q[0];
  wire fall_sec = !rx_sec && rx_prev_q[1];
  wire rx_any = fall_pri || fall_sec;
  wire rx_half = qtick && (rq_cnt_q == 2'h1) &&
                 (rx_state_q == cnp_pkg::RX_HALF);
  wire rx_mid = qtick && (rq_cnt_q == 2'(cnp_pkg::QTICKS_PER_BIT - 1));
  wire rx_last_bit = (rbit_q == 5'(cnp_pkg::PKT_BITS - 1));
  wire in_store = (rx_state_q == cnp_pkg::RX_STORE);
  wire wr_low = in_store && (wcnt_q != 3'h0) &&
                (wcnt_q <= 3'(cnp_pkg::WR_LOW_CYC));
  wire store_end = in_store && (wcnt_q == 3'(cnp_pkg::WR_LOW_CYC + 1));

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || rx_state_q == cnp_pkg::RX_IDLE || rx_mid || rx_half) begin
      rq_cnt_q <= 2'h0;
    end else if (qtick) begin
      rq_cnt_q <= rq_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rx_state_q <= cnp_pkg::RX_IDLE;
      rx_sel_q <= 1'b0;
      rbit_q <= 5'h00;
      rsh_q <= '0;
      wcnt_q <= 3'h0;
    end else begin
      unique case (rx_state_q)
        cnp_pkg::RX_IDLE: begin
          if (!rx_blocked && rx_any) begin
            rx_sel_q <= !fall_pri; // R3
            rx_state_q <= cnp_pkg::RX_HALF;
          end
        end
        cnp_pkg::RX_HALF: begin
          if (rx_blocked) begin
            rx_state_q <= cnp_pkg::RX_IDLE;
          end else if (rx_half) begin
            rbit_q <= 5'h00;
            rx_state_q <= rx_bit ? cnp_pkg::RX_IDLE : cnp_pkg::RX_DATA;
          end
        end
        cnp_pkg::RX_DATA: begin
          if (rx_blocked) begin
            rx_state_q <= cnp_pkg::RX_IDLE;
          end else if (rx_mid) begin
            rsh_q <= {rx_bit, rsh_q[cnp_pkg::PKT_BITS-1:1]};
            rbit_q <= rbit_q + 5'h01;
            if (rx_last_bit) begin
              wcnt_q <= 3'h0;
              rx_state_q <= cnp_pkg::RX_STORE;
            end
          end
        end
        cnp_pkg::RX_STORE: begin
          wcnt_q <= wcnt_q + 3'h1;
          if (store_end) begin
            rx_state_q <= cnp_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rx_resp_q <= '0;
      rx_valid_q <= 1'b0;
      req_flag_q <= 1'b0;
      rx_last_evt_q <= 1'b0;
      rd_n_q <= 1'b0;
      wr_n_q <= 1'b1;
    end else begin
      rx_valid_q <= store_end;
      rx_last_evt_q <= store_end && rx_last_i; // R10
      rd_n_q <= in_store; // R12
      wr_n_q <= !wr_low; // R12
      if (store_end) begin
        rx_resp_q <= {rsh_q, rx_sel_q, rx_last_i};
        req_flag_q <= rsh_q[cnp_pkg::REQ_BIT]; // R8
      end
    end
  end

  assign rx_valid_o = rx_valid_q;
  assign rx_resp_o = rx_resp_q;
  assign satellite_request_flag_o = req_flag_q;
  assign buffer_read_strobe_n_o = rd_n_q;
  assign buffer_write_strobe_n_o = wr_n_q;

  // --------------------------------------------------------------------
  // Pulse stretchers
  // --------------------------------------------------------------------
  wire [3:0] pulse_trig = {check_evt_i, rx_last_evt_q, tx_last_evt_q};
  logic [3:0] pulse_out;

  for (genvar i = 0; i < 4; i++) begin : g_pulse
    logic [4:0] cnt_q;
    always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
        cnt_q <= 5'h00;
      end else if (pulse_trig[i]) begin
        cnt_q <= 5'(cnp_pkg::PULSE_CYC); // R19
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
    assign pulse_out[i] = (cnt_q != 5'h00);
  end

  assign last_tx_loaded_pulse_o = pulse_out[0]; // R9
  assign last_rx_stored_pulse_o = pulse_out[1]; // R10
  assign check_out_first_o = pulse_out[2]; // R11
  assign check_out_second_o = pulse_out[3]; // R11

  // --------------------------------------------------------------------
  // Strap status
  // --------------------------------------------------------------------
  logic host_8bit_q;
  logic buf_ok_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      host_8bit_q <= 1'b0;
      buf_ok_q <= 1'b0;
    end else begin
      host_8bit_q <= !host_width_select_i; // R6
      buf_ok_q <= buffer_type_select_i; // R13
    end
  end

  assign host_bus_8bit_o = host_8bit_q;
  assign buffer_type_ok_o = buf_ok_q;

endmodule : cnp_top

//--- tb/cnp_properties.sv
// Purpose: Port level properties of the network port block
// Assumes: Straps static between resets
// Notes: Attached to the top by bind
`timescale 1ns/1ps
module cnp_properties (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic duplex_select_i,
  input wire logic tx_valid_i,
  input wire cnp_pkg::cnp_tx_req_s tx_req_i,
  input wire logic tx_ready_o,
  input wire logic serial_out_o,
  input wire logic line_drive_gate_o,
  input wire logic rx_valid_o,
  input wire cnp_pkg::cnp_rx_resp_s rx_resp_o,
  input wire logic satellite_request_flag_o,
  input wire logic [1:0] check_evt_i,
  input wire logic check_out_first_o,
  input wire logic check_out_second_o,
  input wire logic last_tx_loaded_pulse_o,
  input wire logic last_rx_stored_pulse_o,
  input wire logic buffer_read_strobe_n_o,
  input wire logic buffer_write_strobe_n_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  logic take;
  assign take = tx_valid_i && tx_ready_o;
  sequence s_start; !tx_ready_o ##1 !serial_out_o; endsequence
  sequence s_txp; last_tx_loaded_pulse_o [*8]; endsequence
  sequence s_wr; !buffer_write_strobe_n_o [*5] ##1 buffer_write_strobe_n_o;
  endsequence
  property p_take; take |=> s_start; endproperty
  property p_gate; take |-> ##2 line_drive_gate_o; endproperty
  property p_full; $past(rstn_i) && duplex_select_i |-> line_drive_gate_o;
  endproperty
  property p_half; $past(rstn_i) && !duplex_select_i && tx_ready_o &&
    $past(tx_ready_o) |-> !line_drive_gate_o; endproperty
  property p_ltx; take && tx_req_i.last |-> ##2 s_txp; endproperty
  property p_check_out_first; check_evt_i[0] |=> check_out_first_o [*8]; endproperty
  property p_check_out_second; $fell(check_out_second_o) |-> $past(check_evt_i[1], 17);
  endproperty
  property p_wr; $fell(buffer_write_strobe_n_o) |-> $past(
    buffer_read_strobe_n_o) ##0 (buffer_read_strobe_n_o throughout s_wr);
  endproperty
  property p_done; $rose(buffer_write_strobe_n_o) |-> rx_valid_o;
  endproperty
  property p_lrx; rx_valid_o && rx_resp_o.last |=> last_rx_stored_pulse_o;
  endproperty
  property p_flag; satellite_request_flag_o == rx_resp_o.data[15];
  endproperty
  a_take: assert property (p_take) else $error("no start bit");
  a_gate: assert property (p_gate) else $error("gate low in frame");
  a_full: assert property (p_full) else $error("gate low full");
  a_half: assert property (p_half) else $error("gate high idle");
  a_ltx: assert property (p_ltx) else $error("last tx pulse");
  a_check_out_first: assert property (p_check_out_first) else $error("check one pulse");
  a_check_out_second: assert property (p_check_out_second) else $error("check two length");
  a_wr: assert property (p_wr) else $error("write strobe shape");
  a_done: assert property (p_done) else $error("no rx valid");
  a_lrx: assert property (p_lrx) else $error("last rx pulse");
  a_flag: assert property (p_flag) else $error("request flag");
endmodule : cnp_properties

bind cnp_top cnp_properties chk_u (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .duplex_select_i(duplex_select_i), .tx_valid_i(tx_valid_i),
  .tx_req_i(tx_req_i), .tx_ready_o(tx_ready_o),
  .serial_out_o(serial_out_o), .line_drive_gate_o(line_drive_gate_o),
  .rx_valid_o(rx_valid_o), .rx_resp_o(rx_resp_o),
  .satellite_request_flag_o(satellite_request_flag_o),
  .check_evt_i(check_evt_i), .check_out_first_o(check_out_first_o),
  .check_out_second_o(check_out_second_o),
  .last_tx_loaded_pulse_o(last_tx_loaded_pulse_o),
  .last_rx_stored_pulse_o(last_rx_stored_pulse_o),
  .buffer_read_strobe_n_o(buffer_read_strobe_n_o),
  .buffer_write_strobe_n_o(buffer_write_strobe_n_o)
);

//--- tb/cnp_satellite.sv
// Purpose: Satellite side model sending response frames
// Assumes: Bit of four external baud clocks, 80 core cycles
// Notes: Lines idle high as with pull-ups
`timescale 1ns/1ps
module cnp_satellite (
  input wire logic clk_sys_i,
  output logic serial_in_primary_o,
  output logic serial_in_secondary_o,
  output logic ext_baud_clock_o
);
  initial begin
    serial_in_primary_o = 1'b1;
    serial_in_secondary_o = 1'b1;
    ext_baud_clock_o = 1'b1;
    #13;
    forever #40 ext_baud_clock_o = ~ext_baud_clock_o;
  end
  // Low start bit, then data LSB first
  task automatic send(input logic [15:0] dp, input logic [15:0] ds,
      input logic [1:0] sel);
    logic [16:0] fp;
    logic [16:0] fs;
    fp = {dp, 1'b0};
    fs = {ds, 1'b0};
    for (int b = 0; b < 17; b++) begin
      @(negedge clk_sys_i);
      serial_in_primary_o = sel[0] ? fp[b] : 1'b1;
      serial_in_secondary_o = sel[1] ? fs[b] : 1'b1;
      repeat (79) @(negedge clk_sys_i);
    end
    @(negedge clk_sys_i);
    serial_in_primary_o = 1'b1;
    serial_in_secondary_o = 1'b1;
  endtask : send
endmodule : cnp_satellite

//--- tb/cnp_top_tb_top.sv
// Purpose: Self-checking bench of the network port block
// Assumes: External baud clock, 80 core cycles a bit
// Notes: Expected frames wait in queues for the monitors
`timescale 1ns/1ps
module cnp_top_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic duplex = 1'b1;
  logic width = 1'b0;
  logic tx_valid = 1'b0;
  logic rx_last = 1'b0;
  logic [1:0] evt = 2'h0;
  logic [31:0] evt_r;
  logic [15:0] got;
  logic idle_lvl;
  cnp_pkg::cnp_rx_resp_s e_rx;
  cnp_pkg::cnp_tx_req_s tx_req = '0;
  cnp_pkg::cnp_rx_resp_s rx_resp;
  cnp_pkg::cnp_rx_resp_s rx_q[$];
  logic [15:0] tx_q[$];
  logic tx_ready, ser_out, gate, rx_valid, flag, check_out_first, check_out_second, pls_tx, pls_rx;
  logic rd_n, wr_n, h8, buf_ok, s_pri, s_sec, ext_clk;
  int seed = 69;
  int miscompares = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  cnp_top dut_u (
    .clk_sys_i(clk), .rstn_i(rstn), .duplex_select_i(duplex),
    .host_width_select_i(width), .ext_baud_clock_i(ext_clk),
    .rate_sel_lo_i(1'b0), .rate_sel_hi_i(1'b0),
    .buffer_type_select_i(1'b1),
    .serial_in_primary_i(s_pri), .serial_in_secondary_i(s_sec),
    .tx_valid_i(tx_valid), .tx_req_i(tx_req), .tx_ready_o(tx_ready),
    .serial_out_o(ser_out), .line_drive_gate_o(gate), .rx_last_i(rx_last),
    .rx_valid_o(rx_valid), .rx_resp_o(rx_resp),
    .satellite_request_flag_o(flag), .check_evt_i(evt),
    .check_out_first_o(check_out_first), .check_out_second_o(check_out_second),
    .last_tx_loaded_pulse_o(pls_tx), .last_rx_stored_pulse_o(pls_rx),
    .buffer_read_strobe_n_o(rd_n), .buffer_write_strobe_n_o(wr_n),
    .host_bus_8bit_o(h8), .buffer_type_ok_o(buf_ok)
  );
  cnp_satellite partner_u (.clk_sys_i(clk), .serial_in_primary_o(s_pri),
    .serial_in_secondary_o(s_sec), .ext_baud_clock_o(ext_clk));
  always @(negedge clk) begin
    evt_r = $random(seed);
    evt <= (evt_r[7:3] == 5'h0) ? evt_r[1:0] : 2'h0;
  end
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic do_reset(input logic fd);
    @(negedge clk);
    rstn = 1'b0;
    duplex = fd;
    width = 1'($random(seed));
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk(18'(h8), 18'(!width));
    chk(18'(buf_ok), 18'h1);
    chk(18'(gate), 18'(fd));
  endtask : do_reset
  task automatic send_tx(input logic [15:0] d);
    int n;
    n = 0;
    while (tx_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    tx_q.push_back(d);
    tx_req = {d, 1'($random(seed))};
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask : send_tx
  task automatic send_rx(input logic [1:0] sel, input logic [15:0] dp,
      input logic [15:0] ds, input logic keep);
    cnp_pkg::cnp_rx_resp_s e;
    rx_last = 1'($random(seed));
    e = {sel[0] ? dp : ds, !sel[0], rx_last};
    if (keep) rx_q.push_back(e);
    partner_u.send(dp, ds, sel);
    repeat (40) @(negedge clk);
  endtask : send_rx
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      if (rx_q.size() == 0) chk(18'(rx_resp), ~18'(rx_resp));
      else begin
        e_rx = rx_q.pop_front();
        chk(rx_resp, e_rx);
        chk(18'(flag), 18'(e_rx.data[15]));
      end
    end
  end
  // Samples each bit near its middle
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      repeat (40) @(posedge clk);
      chk(18'(ser_out), 18'h0);
      repeat (80) @(posedge clk);
      for (int b = 0; b < 16; b++) begin
        got[b] = ser_out;
        if (!duplex) chk(18'(gate), 18'h1);
        if (b < 15) repeat (80) @(posedge clk);
      end
      chk(18'(got), 18'(tx_q.pop_front()));
    end
  end
  initial begin
    fork
      begin
        #160000;
        miscompares++;
        close_out();
      end
    join_none
    do_reset(1'b1);
    for (int i = 0; i < 6; i++) begin
      fork
        send_tx(16'($random(seed)));
        send_rx(2'(i % 3 + 1), 16'($random(seed)), 16'($random(seed)),
          1'b1);
      join
    end
    send_tx(16'h0001);
    send_tx(16'h8000);
    repeat (1500) @(negedge clk);
    idle_lvl = ser_out;
    repeat (160) @(negedge clk);
    chk(18'(ser_out), 18'(!idle_lvl));
    do_reset(1'b0);
    fork
      send_tx(16'($random(seed)));
      begin
        repeat (100) @(negedge clk);
        send_rx(2'h1, 16'hffff, 16'hffff, 1'b0);
      end
    join
    for (int i = 0; i < 3; i++) begin
      send_rx(2'(i + 1), 16'($random(seed)), 16'($random(seed)), 1'b1);
      send_tx(16'($random(seed)));
      repeat (1450) @(negedge clk);
    end
    chk(18'(rx_q.size()), 18'h0);
    chk(18'(tx_q.size()), 18'h0);
    close_out();
  end
endmodule : cnp_top_tb_top
